//--- core/sada_defs.vh
// constants for the scalar add/divide datapath
`ifndef SADA_DEFS_VH
`define SADA_DEFS_VH

// operation codes
`define SADA_OP_ADD_SHORT 4'h0
`define SADA_OP_ADD_LONG 4'h1
`define SADA_OP_ADD_HALF 4'h2
`define SADA_OP_PS_DOWN 4'h3
`define SADA_OP_PS_UP 4'h4
`define SADA_OP_ADDI_D 4'h5
`define SADA_OP_ADDI_P 4'h6
`define SADA_OP_ADDI_I 4'h7
`define SADA_OP_DIVS 4'h8
`define SADA_OP_DIVQ 4'h9

// arith_status_word bit positions
`define SADA_ZERO_BIT 0
`define SADA_NEG_BIT 1
`define SADA_CARRY_BIT 2
`define SADA_OVF_BIT 3
`define SADA_STICKY_BIT 4
`define SADA_QUOT_BIT 5
`define SADA_RND_BIT 6
`define SADA_STAT_W 7
`define SADA_STAT_RESET 7'h00

// register port offsets (byte addresses, four words each except status)
`define SADA_ADDR_W 8
`define SADA_OFS_INDEX 8'h00
`define SADA_OFS_LENGTH 8'h10
`define SADA_OFS_BASE 8'h20
`define SADA_OFS_STATUS 8'h30

// arithmetic constants
`define SADA_HALF_MAX 16'h7FFF
`define SADA_HALF_MIN 16'h8000
`define SADA_WORD_MAX 32'h7FFFFFFF
`define SADA_WORD_MIN 32'h80000000
`define SADA_ROUND_BIAS 16'h8000
`define SADA_PRESCALE_SH 4
`define SADA_ISTEP_SMALL 32'h00000002
`define SADA_ISTEP_LARGE 32'h00000004

`endif

//--- core/sada_rnd_half.v
// biased round and saturate of a wide sum to a half-word
`timescale 1ns/1ps
`default_nettype none
`include "sada_defs.vh"

module sada_rnd_half #(
   parameter W = 34
) (
   input wire [W-1:0] sum_in, // signed sum, radix point at bit 16
   output reg [15:0] half_out, // rounded, saturated upper half
   output reg sat_out // high when clamped
);

   reg [W:0] rnd;
   reg [W-16:0] top;

   // bias is added regardless of any rounding mode
   always @* begin
      rnd = {sum_in[W-1], sum_in} + {{(W-15){1'b0}}, `SADA_ROUND_BIAS};
      top = rnd[W:16];
      if (!top[W-16] && (top[W-16:15] != {(W-30){1'b0}})) begin
         half_out = `SADA_HALF_MAX;
         sat_out = 1'b1;
      end else if (top[W-16] && (top[W-16:15] != {(W-30){1'b1}})) begin
         half_out = `SADA_HALF_MIN;
         sat_out = 1'b1;
      end else begin
         half_out = top[15:0];
         sat_out = 1'b0;
      end
   end

endmodule // sada_rnd_half
`default_nettype wire

//--- core/sada_alu.v
// scalar add / prescale / add-immediate / divide-step datapath
`timescale 1ns/1ps
`default_nettype none
`include "sada_defs.vh"

module sada_alu (
   input wire sys_clk_in, // core clock, 10 MHz
   input wire rst_b_in, // async reset, active low
   input wire op_valid_in, // instruction issued this cycle
   input wire [3:0] op_code_in, // operation select
   input wire op_parallel_in, // issued as part of a parallel group
   input wire op_sat_in, // saturate option (long add, half add)
   input wire op_sub_in, // subtract for prescale forms
   input wire src0_hi_in, // half add: take upper half of src0
   input wire src1_hi_in, // half add: take upper half of src1
   input wire dst_hi_in, // half results: write upper half
   input wire [31:0] src0_in, // first operand / dividend / register
   input wire [31:0] src1_in, // second operand / divisor
   input wire [6:0] imm_in, // short_signed_constant
   input wire [1:0] ireg_sel_in, // index register select
   input wire istep4_in, // index step 4 instead of 2
   input wire [7:0] reg_addr_in, // register port address
   input wire [31:0] reg_wdata_in, // register port write data
   input wire reg_wr_in, // register write strobe
   input wire reg_rd_in, // register read strobe
   output reg [31:0] reg_rdata_out, // read data, cycle after strobe
   output reg res_valid_out, // one-cycle result pulse
   output reg [31:0] res_data_out, // result word
   output reg res_half_out, // result is a half-word
   output reg res_dst_hi_out, // half result goes to upper half
   output reg reject_out, // one-cycle refusal pulse
   output reg [6:0] status_out // arith_status_word
);

   // circular addressing set, deliberately without reset
   reg [31:0] index_reg [0:3];
   reg [31:0] length_reg [0:3];
   reg [31:0] base_reg [0:3];
   reg [`SADA_STAT_W-1:0] status_reg;

   reg [31:0] res_next;
   reg [`SADA_STAT_W-1:0] stat_next;
   reg [`SADA_STAT_W-1:0] stat_base;
   reg half_next;
   reg refuse;
   reg exec;
   reg iwrite;

   // intermediate values of the combinational datapath
   reg [32:0] sum33;
   reg [16:0] sum17;
   reg [15:0] ha;
   reg [15:0] hb;
   reg [15:0] hres;
   reg [31:0] imm32;
   reg [31:0] ps_a;
   reg [31:0] ps_b;
   reg [32:0] ps_dsum;
   reg [36:0] up_a;
   reg [36:0] up_b;
   reg [36:0] ps_usum;
   reg [31:0] istep;
   reg [31:0] inew;
   reg [31:0] ilimit;
   reg [15:0] dvs;
   reg [15:0] dtop;
   reg aq;
   reg ovf;

   // rounder outputs, one per prescale direction
   wire [15:0] dn_half;
   wire [15:0] up_half;
   wire dn_sat;
   wire up_sat;

   // prescale down: 33-bit sum sign-extended to 34
   sada_rnd_half #(.W(34)) u_rnd_down (
      .sum_in({ps_dsum[32], ps_dsum}),
      .half_out(dn_half),
      .sat_out(dn_sat)
   );

   // prescale up: 37-bit sum keeps every shifted bit
   sada_rnd_half #(.W(37)) u_rnd_up (
      .sum_in(ps_usum),
      .half_out(up_half),
      .sat_out(up_sat)
   );

   // parallel-issue screening
   // a refused op leaves result, flags and index registers untouched
   always @* begin
      case (op_code_in)
         `SADA_OP_ADD_SHORT: refuse = op_parallel_in;
         `SADA_OP_ADDI_D,
         `SADA_OP_ADDI_P: refuse = op_parallel_in;
         `SADA_OP_DIVS,
         `SADA_OP_DIVQ: refuse = op_parallel_in;
         `SADA_OP_ADD_LONG,
         `SADA_OP_ADD_HALF,
         `SADA_OP_PS_DOWN,
         `SADA_OP_PS_UP,
         `SADA_OP_ADDI_I: refuse = 1'b0;
         default: refuse = 1'b1; // unknown code is never executed
      endcase
      exec = op_valid_in && !refuse;
   end

   // software writes land first, so hardware-set bits win afterwards
   // bits that the op does not touch keep the written value
   always @* begin
      if (reg_wr_in && reg_addr_in == `SADA_OFS_STATUS) begin
         stat_base = reg_wdata_in[`SADA_STAT_W-1:0];
      end else begin
         stat_base = status_reg;
      end
   end

   // shared operand preparation
   always @* begin
      imm32 = {{25{imm_in[6]}}, imm_in};
      ha = src0_hi_in ? src0_in[31:16] : src0_in[15:0];
      hb = src1_hi_in ? src1_in[31:16] : src1_in[15:0];
      // arithmetic shift right by four on both operands
      ps_a = $signed(src0_in) >>> `SADA_PRESCALE_SH;
      ps_b = $signed(src1_in) >>> `SADA_PRESCALE_SH;
      if (op_sub_in) begin
         ps_dsum = {ps_a[31], ps_a} - {ps_b[31], ps_b};
      end else begin
         ps_dsum = {ps_a[31], ps_a} + {ps_b[31], ps_b};
      end
      // shift left by four into a wider sum, nothing lost
      up_a = {{1{src0_in[31]}}, src0_in, 4'h0};
      up_b = {{1{src1_in[31]}}, src1_in, 4'h0};
      if (op_sub_in) begin
         ps_usum = up_a - up_b;
      end else begin
         ps_usum = up_a + up_b;
      end
      // divisor is the low half only, upper half ignored
      dvs = src1_in[15:0];
      // index step comes from the step select, never from the constant
      istep = istep4_in ? `SADA_ISTEP_LARGE : `SADA_ISTEP_SMALL;
      inew = index_reg[ireg_sel_in] + istep;
      // limit may wrap past the top of memory; keep buffers below it
      ilimit = base_reg[ireg_sel_in] + length_reg[ireg_sel_in];
   end

   // operation datapath and flag update
   always @* begin
      res_next = 32'h00000000;
      stat_next = stat_base;
      half_next = 1'b0;
      iwrite = 1'b0;
      sum33 = 33'h000000000;
      sum17 = 17'h00000;
      hres = 16'h0000;
      dtop = 16'h0000;
      aq = 1'b0;
      ovf = 1'b0;
      case (op_code_in)
         `SADA_OP_ADD_SHORT,
         `SADA_OP_ADD_LONG,
         `SADA_OP_ADDI_D: begin
            if (op_code_in == `SADA_OP_ADDI_D) begin
               sum33 = {1'b0, src0_in} + {1'b0, imm32};
            end else begin
               sum33 = {1'b0, src0_in} + {1'b0, src1_in};
            end
            // carry and overflow come from the raw sum, even when clamped
            ovf = (src0_in[31] == (op_code_in == `SADA_OP_ADDI_D ?
                   imm32[31] : src1_in[31])) &&
                  (sum33[31] != src0_in[31]);
            res_next = sum33[31:0];
            // only the long form with the option may clamp
            if (op_code_in == `SADA_OP_ADD_LONG && op_sat_in && ovf) begin
               res_next = src0_in[31] ? `SADA_WORD_MIN : `SADA_WORD_MAX;
            end
            // flags from the written result
            stat_next[`SADA_ZERO_BIT] = (res_next == 32'h00000000);
            stat_next[`SADA_NEG_BIT] = res_next[31];
            stat_next[`SADA_CARRY_BIT] = sum33[32];
            stat_next[`SADA_OVF_BIT] = ovf;
            if (ovf) begin
               stat_next[`SADA_STICKY_BIT] = 1'b1;
            end
         end
         `SADA_OP_ADD_HALF: begin
            // carry is the carry out of the half-word adder
            sum17 = {1'b0, ha} + {1'b0, hb};
            ovf = (ha[15] == hb[15]) && (sum17[15] != ha[15]);
            hres = sum17[15:0]; // wrapped sum without saturation
            if (op_sat_in && ovf) begin
               hres = ha[15] ? `SADA_HALF_MIN : `SADA_HALF_MAX;
            end
            res_next = {16'h0000, hres};
            half_next = 1'b1;
            stat_next[`SADA_ZERO_BIT] = (hres == 16'h0000);
            stat_next[`SADA_NEG_BIT] = hres[15];
            stat_next[`SADA_CARRY_BIT] = sum17[16];
            stat_next[`SADA_OVF_BIT] = ovf;
            if (ovf) begin
               stat_next[`SADA_STICKY_BIT] = 1'b1;
            end
         end
         `SADA_OP_PS_DOWN: begin
            // rounding select bit is never consulted here
            res_next = {16'h0000, dn_half};
            half_next = 1'b1;
            stat_next[`SADA_ZERO_BIT] = (dn_half == 16'h0000);
            stat_next[`SADA_NEG_BIT] = dn_half[15];
            stat_next[`SADA_OVF_BIT] = 1'b0;
         end
         `SADA_OP_PS_UP: begin
            res_next = {16'h0000, up_half};
            half_next = 1'b1;
            stat_next[`SADA_ZERO_BIT] = (up_half == 16'h0000);
            stat_next[`SADA_NEG_BIT] = up_half[15];
            // clamping of the rounded upper half is what drives overflow
            stat_next[`SADA_OVF_BIT] = up_sat;
            if (up_sat) begin
               stat_next[`SADA_STICKY_BIT] = 1'b1;
            end
         end
         `SADA_OP_ADDI_P: begin
            // plain pointer add, flags untouched
            res_next = src0_in + imm32;
         end
         `SADA_OP_ADDI_I: begin
            // flags untouched; wrap only with a nonzero length
            iwrite = 1'b1;
            res_next = inew;
            if (length_reg[ireg_sel_in] != 32'h00000000 &&
                inew >= ilimit) begin
               res_next = inew - length_reg[ireg_sel_in];
            end
         end
         `SADA_OP_DIVS: begin
            aq = src0_in[31] ^ dvs[15];
            res_next = {src0_in[30:0], aq};
            stat_next[`SADA_QUOT_BIT] = aq;
         end
         `SADA_OP_DIVQ: begin
            // the program clears the flag first for unsigned work
            if (stat_base[`SADA_QUOT_BIT]) begin
               dtop = src0_in[31:16] + dvs;
            end else begin
               dtop = src0_in[31:16] - dvs;
            end
            // new flag from the msb of the partial remainder
            aq = dtop[15] ^ dvs[15];
            res_next = {dtop[14:0], src0_in[15:0], ~aq};
            stat_next[`SADA_QUOT_BIT] = aq;
         end
         default: begin
            res_next = 32'h00000000;
         end
      endcase
   end

   // result, flags and refusal leave together
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         status_reg <= `SADA_STAT_RESET;
         res_valid_out <= 1'b0;
         // result word then holds until the next accepted op
         res_data_out <= 32'h00000000;
         res_half_out <= 1'b0;
         res_dst_hi_out <= 1'b0;
         reject_out <= 1'b0;
      end else begin
         res_valid_out <= exec;
         reject_out <= op_valid_in && refuse;
         if (exec) begin
            status_reg <= stat_next;
            res_data_out <= res_next;
            res_half_out <= half_next;
            res_dst_hi_out <= dst_hi_in;
         end else begin
            // refused ops still let a software status write through
            status_reg <= stat_base;
         end
      end
   end

   // status output mirrors the flag register, one copy per edge
   // a duplicate flop so the port comes straight from a register
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         status_out <= `SADA_STAT_RESET;
      end else if (exec) begin
         status_out <= stat_next;
      end else begin
         status_out <= stat_base;
      end
   end

   // circular set: no reset branch, contents undefined until written
   // reads before a first write return unknown data
   always @(posedge sys_clk_in) begin
      if (reg_wr_in) begin
         case (reg_addr_in[7:4])
            4'h0: index_reg[reg_addr_in[3:2]] <= reg_wdata_in;
            4'h1: length_reg[reg_addr_in[3:2]] <= reg_wdata_in;
            4'h2: base_reg[reg_addr_in[3:2]] <= reg_wdata_in;
            default: ;
         endcase
      end
      // instruction update wins over a same-cycle software write
      if (exec && iwrite) begin
         index_reg[ireg_sel_in] <= res_next;
      end
   end

   // read port: data valid only in the cycle after the strobe
   // zero outside the data cycle so several ports can be or-ed
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 32'h00000000;
      end else if (reg_rd_in) begin
         if (reg_addr_in[1:0] != 2'h0) begin
            reg_rdata_out <= 32'h00000000; // unaligned reads as zero
         end else begin
            case (reg_addr_in[7:4])
               4'h0: reg_rdata_out <= index_reg[reg_addr_in[3:2]];
               4'h1: reg_rdata_out <= length_reg[reg_addr_in[3:2]];
               4'h2: reg_rdata_out <= base_reg[reg_addr_in[3:2]];
               4'h3: begin
                  if (reg_addr_in[3:2] == 2'h0) begin
                     reg_rdata_out <= {25'h0000000, status_reg};
                  end else begin
                     reg_rdata_out <= 32'h00000000;
                  end
               end
               default: reg_rdata_out <= 32'h00000000;
            endcase
         end
      end else begin
         reg_rdata_out <= 32'h00000000;
      end
   end

endmodule // sada_alu
`default_nettype wire

//--- tb/sada_alu_asserts.sv
// concurrent checks on the scalar add/divide datapath ports
`timescale 1ns/1ps
`default_nettype none
module sada_alu_asserts (
   input wire logic sys_clk_in, // core clock
   input wire logic rst_b_in, // async reset, active low
   input wire logic op_valid_in, // issue
   input wire logic [3:0] op_code_in, // op select
   input wire logic op_parallel_in, // parallel group
   input wire logic [31:0] src0_in, // dividend
   input wire logic [31:0] src1_in, // divisor
   input wire logic reg_wr_in, // register write
   input wire logic [31:0] res_data_out, // result word
   input wire logic res_valid_out, // result pulse
   input wire logic reject_out, // refusal pulse
   input wire logic [6:0] status_out // status word
);
   logic [31:0] s0_q;
   logic [31:0] s1_q;
   logic [6:0] st_q;
   // ops that may never join a parallel group
   wire logic p_short = op_parallel_in && op_code_in == 4'h0;
   wire logic p_addi = op_parallel_in
      && (op_code_in == 4'h5 || op_code_in == 4'h6);
   wire logic p_div = op_parallel_in && op_code_in[3:1] == 3'h4;
   wire logic acc = op_valid_in && op_code_in <= 4'h9 && !p_short
      && !p_addi && !p_div;
   wire logic quiet = acc && !reg_wr_in;
   // operands seen one edge back, slices kept out of $past
   always_ff @(posedge sys_clk_in) begin
      s0_q <= src0_in;
      s1_q <= src1_in;
      st_q <= status_out;
   end
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   AST_ACCEPT: assert property (
      acc |=> res_valid_out && !reject_out)
      else $error("accepted op gave no result");
   AST_PAR_SHORT: assert property (
      op_valid_in && p_short |=> reject_out && !res_valid_out)
      else $error("parallel short add not refused");
   AST_PAR_ADDI: assert property (
      op_valid_in && p_addi |=> reject_out && !res_valid_out)
      else $error("parallel data or pointer addi not refused");
   AST_PAR_DIV: assert property (
      op_valid_in && p_div && !reg_wr_in |=> reject_out
      && $stable(status_out))
      else $error("parallel divide not refused");
   AST_PSD_FLAGS: assert property (
      quiet && op_code_in == 4'h3 |=> !status_out[3]
      && status_out[0] == (res_data_out[15:0] == 16'h0000)
      && status_out[1] == res_data_out[15] && status_out[6:4] == st_q[6:4]
      && status_out[2] == st_q[2])
      else $error("prescale down flags wrong");
   AST_PSU_FLAGS: assert property (
      acc && op_code_in == 4'h4 |=>
      status_out[0] == (res_data_out[15:0] == 16'h0000)
      && (!status_out[3] || status_out[4]))
      else $error("prescale up flags wrong");
   AST_ADDI_STICKY: assert property (
      acc && op_code_in == 4'h5 |=> !status_out[3] || status_out[4])
      else $error("addi overflow without sticky");
   AST_PTR_FLAGS: assert property (
      quiet && op_code_in[3:1] == 3'h3 |=> status_out == st_q)
      else $error("pointer or index addi changed flags");
   AST_DIVS: assert property (
      acc && op_code_in == 4'h8 |=> status_out[5] == (s0_q[31] ^ s1_q[15])
      && res_data_out == {s0_q[30:0], status_out[5]})
      else $error("divide sign step wrong");
   AST_DIVQ_LSB: assert property (
      acc && op_code_in == 4'h9 |=> res_data_out[0] == !status_out[5])
      else $error("divide quotient bit wrong");
   AST_DIV_FLAGS: assert property (
      quiet && op_code_in[3:1] == 3'h4 |=> status_out[4:0] == st_q[4:0]
      && status_out[6] == st_q[6])
      else $error("divide touched other flags");
   cover property (acc && op_code_in == 4'h9);
   cover property (op_valid_in && p_addi);
   cover property (op_valid_in && p_div);
   cover property (res_valid_out && status_out[3]);
endmodule // sada_alu_asserts
bind sada_alu sada_alu_asserts u_chk (.sys_clk_in(sys_clk_in),
   .rst_b_in(rst_b_in), .op_valid_in(op_valid_in), .op_code_in(op_code_in),
   .op_parallel_in(op_parallel_in), .src0_in(src0_in), .src1_in(src1_in),
   .reg_wr_in(reg_wr_in), .res_data_out(res_data_out),
   .res_valid_out(res_valid_out), .reject_out(reject_out),
   .status_out(status_out));
`default_nettype wire

//--- tb/sada_rf_model.sv
// register file stand-in holding the last result as a data register
`timescale 1ns/1ps
`default_nettype none
module sada_rf_model (
   input wire logic clk_in, // core clock
   input wire logic rst_b_in, // async reset, active low
   input wire logic res_valid_in, // result pulse
   input wire logic [31:0] res_data_in, // result word
   output logic [31:0] dreg_out // stored data register
);
   // written only on the result pulse, so a stale word never feeds back
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dreg_out <= 32'h0;
      end else if (res_valid_in) begin
         dreg_out <= res_data_in;
      end
   end
endmodule // sada_rf_model
`default_nettype wire

//--- tb/sada_alu_tb_top.sv
// self-checking bench for the scalar add/divide datapath
`timescale 1ns/1ps
`default_nettype none
module sada_alu_tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic vld = 1'b0;
   logic [3:0] opc = 4'h0;
   logic par = 1'b0;
   logic sat = 1'b0;
   logic sub = 1'b0;
   logic s0hi = 1'b0;
   logic s1hi = 1'b0;
   logic dhi = 1'b0;
   logic [31:0] s0 = 32'h0;
   logic [31:0] s1 = 32'h0;
   logic [6:0] imm = 7'h0;
   logic [1:0] isel = 2'h0;
   logic ist4 = 1'b0;
   logic [7:0] ra = 8'h0;
   logic [31:0] rwd = 32'h0;
   logic rwr = 1'b0;
   logic rrd = 1'b0;
   wire logic [31:0] rdata;
   wire logic [31:0] rdat;
   wire logic [31:0] dreg;
   wire logic rv;
   wire logic rej;
   wire logic [6:0] st;
   wire logic rhalf;
   wire logic rdhi;
   int num_errors = 0;
   int comparisons = 0;
   logic [31:0] got;
   logic [31:0] r;
   logic [31:0] d;
   logic aq;
   logic [3:0] bad_ops [6] = '{4'h0, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA};
   sada_alu uut (.sys_clk_in(clk), .rst_b_in(rst_b), .op_valid_in(vld),
      .op_code_in(opc), .op_parallel_in(par), .op_sat_in(sat),
      .op_sub_in(sub), .src0_hi_in(s0hi), .src1_hi_in(s1hi), .dst_hi_in(dhi),
      .src0_in(s0), .src1_in(s1), .imm_in(imm), .ireg_sel_in(isel),
      .istep4_in(ist4), .reg_addr_in(ra), .reg_wdata_in(rwd),
      .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rdata),
      .res_valid_out(rv), .res_data_out(rdat), .res_half_out(rhalf),
      .res_dst_hi_out(rdhi), .reject_out(rej), .status_out(st));
   sada_rf_model u_rf (.clk_in(clk), .rst_b_in(rst_b), .res_valid_in(rv),
      .res_data_in(rdat), .dreg_out(dreg));
   // 10 MHz core clock
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic check(input string nm, input logic [31:0] g,
      input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one instruction, result sampled once its edge has landed
   task automatic issue(input logic [3:0] o, input logic p,
      input logic [4:0] f, input logic [31:0] a, input logic [31:0] b,
      input logic [6:0] m);
      @(posedge clk);
      {vld, opc, par, sat, sub, s0hi, s1hi, dhi, s0, s1, imm, isel, ist4}
         <= {1'b1, o, p, f, a, b, m, m[1:0], m[2]};
      @(posedge clk);
      vld <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {ra, rwd, rwr} <= {a, v, 1'b1};
      @(posedge clk);
      rwr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      {ra, rrd} <= {a, 1'b1};
      @(posedge clk);
      rrd <= 1'b0;
      #1;
      v = rdata;
   endtask
   // status 7F means the flags of that case are not compared
   task automatic tcase(input logic [3:0] o, input logic [4:0] f,
      input logic [31:0] a, input logic [31:0] b, input logic [6:0] m,
      input logic [31:0] e, input logic [6:0] es);
      issue(o, 1'b0, f, a, b, m);
      check("result", rdat, e);
      if (es != 7'h7F) check("status", {25'h0, st}, {25'h0, es});
   endtask
   // own nonrestoring step on the upper half, divisor low half only
   task automatic dstep(input logic [3:0] o);
      // let the stand-in register file take the last result first
      if (o == 4'h9) begin
         @(posedge clk);
         #1;
      end
      issue(o, 1'b0, 5'h00, (o == 4'h8) ? r : dreg, d, 7'h00);
      if (o == 4'h9) r[31:16] = aq ? r[31:16] + d[15:0] : r[31:16] - d[15:0];
      aq = r[31] ^ d[15];
      r = {r[30:0], (o == 4'h9) ? !aq : aq};
      check("dividend", rdat, r);
      check("quotient sign", {31'h0, st[5]}, {31'h0, aq});
   endtask
   // hang guard, far beyond the two hundred or so cycles of the tests
   initial begin
      #(3000 * 100);
      num_errors++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      check("reset status", {25'h0, st}, 32'h0);
      check("reset pulses", {30'h0, rv, rej}, 32'h0);
      check("reset result", rdat, 32'h0);
      wr(8'h30, 32'h40);
      rd(8'h30, got);
      check("status read", got, 32'h40);
      tcase(4'h3, 5'h00, 32'h80000, 32'h0, 7'h0, 32'h1, 7'h40);
      tcase(4'h3, 5'h08, 32'h12340000, 32'h1000000, 7'h0, 32'h113, 7'h40);
      tcase(4'h3, 5'h00, 32'h80000000, 32'h0, 7'h0, 32'hF800, 7'h42);
      tcase(4'h4, 5'h00, 32'h800, 32'h0, 7'h0, 32'h1, 7'h40);
      tcase(4'h4, 5'h00, 32'h8000000, 32'h0, 7'h0, 32'h7FFF, 7'h58);
      tcase(4'h4, 5'h08, 32'h10000, 32'h8000, 7'h0, 32'h8, 7'h50);
      tcase(4'h3, 5'h00, 32'h0, 32'h0, 7'h0, 32'h0, 7'h51);
      wr(8'h30, 32'h0);
      tcase(4'h0, 5'h10, 32'h7FFFFFFF, 32'h1, 7'h0, 32'h80000000, 7'h1A);
      tcase(4'h1, 5'h00, 32'h7FFFFFFF, 32'h1, 7'h0, 32'h80000000, 7'h1A);
      tcase(4'h1, 5'h10, 32'h7FFFFFFF, 32'h1, 7'h0, 32'h7FFFFFFF, 7'h18);
      check("half dest", {30'h0, rhalf, rdhi}, 32'h0);
      tcase(4'h2, 5'h13, 32'h7000, 32'h20000000, 7'h0, 32'h7FFF, 7'h7F);
      check("half dest", {30'h0, rhalf, rdhi}, 32'h3);
      tcase(4'h2, 5'h00, 32'h7000, 32'h2000, 7'h0, 32'h9000, 7'h7F);
      check("half dest", {30'h0, rhalf, rdhi}, 32'h2);
      wr(8'h30, 32'h0);
      tcase(4'h5, 5'h00, 32'h7FFFFFFF, 32'h0, 7'h01, 32'h80000000, 7'h1A);
      tcase(4'h5, 5'h00, 32'hFFFFFFFF, 32'h0, 7'h01, 32'h0, 7'h15);
      tcase(4'h5, 5'h00, 32'h100, 32'h0, 7'h40, 32'hC0, 7'h14);
      tcase(4'h5, 5'h00, 32'h0, 32'h0, 7'h3F, 32'h3F, 7'h10);
      tcase(4'h6, 5'h00, 32'hFFFFFFFF, 32'h0, 7'h01, 32'h0, 7'h10);
      wr(8'h04, 32'h100);
      wr(8'h14, 32'h0);
      issue(4'h7, 1'b1, 5'h00, 32'h0, 32'h0, 7'h01);
      check("index pairs", {31'h0, rv}, 32'h1);
      rd(8'h04, got);
      check("index plain", got, 32'h102);
      wr(8'h14, 32'h8);
      wr(8'h24, 32'h100);
      wr(8'h04, 32'h106);
      issue(4'h7, 1'b0, 5'h00, 32'h0, 32'h0, 7'h05);
      check("index flags", {25'h0, st}, 32'h10);
      rd(8'h04, got);
      check("index wrap", got, 32'h102);
      rd(8'h40, got);
      check("unmapped read", got, 32'h0);
      foreach (bad_ops[k]) begin
         issue(bad_ops[k], 1'b1, 5'h00, 32'h1, 32'h1, 7'h01);
         check("refused", {31'h0, rej}, 32'h1);
      end
      check("status kept", {25'h0, st}, 32'h10);
      issue(4'h1, 1'b1, 5'h00, 32'h1, 32'h2, 7'h0);
      check("long add pairs", rdat, 32'h3);
      wr(8'h30, 32'h0);
      r = 32'd140;
      d = 32'hABCD0005;
      dstep(4'h8);
      repeat (15) dstep(4'h9);
      check("quotient", {16'h0, rdat[15:0]}, 32'd14);
      tcase(4'h0, 5'h00, 32'd100, 32'h0, 7'h0, 32'd100, 7'h7F);
      wr(8'h30, 32'h0);
      r = 32'd100;
      d = 32'h7;
      aq = 1'b0;
      repeat (16) dstep(4'h9);
      complete_run();
   end
endmodule // sada_alu_tb_top
`default_nettype wire
